// ===== hdl/bpa_defines.vh
// Constants for the bidirectional port A block
// How it works
// - Four registers: pin direction, pin level port, output latch, analog select.
// - Eight pins, each usable as input or output.
// - Direction bit one makes the pin an input, driver released.
// - Direction bit zero drives the pin from its latch bit.
// - Port read returns pin levels; port write updates the latch.
// - Latch register reads back latched value at its own address.
// - Pin four input also feeds the timer zero clock input.
// - Pins six and seven are oscillator or I/O per oscillator setting.
// - Oscillator-owned pins read zero in port, direction and latch.
// - Analog select field picks analog or digital for pins five and three to zero.
// - After reset pins 5,3..0 are analog reading zero; pin four digital.
// - Pin four latch output is open drain; a peripheral on pin four and the other pins drive both levels.
// - An enabled sharing peripheral takes over its pin from GPIO.
`ifndef BPA_DEFINES_VH
`define BPA_DEFINES_VH

// Register offsets on the plain register port
`define BPA_ADDR_W        4
`define BPA_OFS_PORT      4'h0
`define BPA_OFS_DIR       4'h1
`define BPA_OFS_LATCH     4'h2
`define BPA_OFS_ADCFG     4'h3

// Widths
`define BPA_DATA_W        8
`define BPA_CFG_W         4

// Reset values
`define BPA_RST_DIR       8'hFF
`define BPA_RST_LATCH     8'h00
`define BPA_RST_CFG       4'h0
`define BPA_ZERO8         8'h00

// Pin roles
`define BPA_PIN_OD        4
`define BPA_OSC_MASK      8'hC0
`define BPA_CFG_MAX       4'hF

`endif

// ===== hdl/bpa_port.v
// Bidirectional port A: registers, pin drivers and pin sharing
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "bpa_defines.vh"

module bpa_port #(
    parameter WIDTH = 8
) (
    input  wire                   core_clk,
    input  wire                   reset,
    input  wire [`BPA_ADDR_W-1:0] reg_addr,
    input  wire [WIDTH-1:0]       reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [WIDTH-1:0]       reg_rdata,
    input  wire [WIDTH-1:0]       pin_in,
    output reg  [WIDTH-1:0]       pin_out,
    output reg  [WIDTH-1:0]       pin_oe,
    input  wire                   osc_on_pins,
    input  wire [WIDTH-1:0]       periph_take,
    input  wire [WIDTH-1:0]       periph_out,
    input  wire [WIDTH-1:0]       periph_oe,
    output reg                    timer_zero_clock_input
);

    // ************************************************
    // Analog decode
    // ************************************************

    // Pins 5,3,2,1,0 are channels 4,3,2,1,0; field counts down the channels
    function [WIDTH-1:0] bpa_analog;
        input [`BPA_CFG_W-1:0] cfg;
        reg   [`BPA_CFG_W-1:0] cnt;
        begin
            cnt = `BPA_CFG_MAX - cfg;
            bpa_analog = {WIDTH{1'b0}};
            bpa_analog[0] = (cnt > 4'h0);
            bpa_analog[1] = (cnt > 4'h1);
            bpa_analog[2] = (cnt > 4'h2);
            bpa_analog[3] = (cnt > 4'h3);
            bpa_analog[5] = (cnt > 4'h4);
        end
    endfunction

    // ************************************************
    // Registers
    // ************************************************

    reg  [WIDTH-1:0]       dir_reg;
    reg  [WIDTH-1:0]       dir_next;
    reg  [WIDTH-1:0]       latch_reg;
    reg  [WIDTH-1:0]       latch_next;
    reg  [`BPA_CFG_W-1:0]  cfg_reg;
    reg  [`BPA_CFG_W-1:0]  cfg_next;
    reg  [WIDTH-1:0]       rdata_next;
    wire [WIDTH-1:0]       analog_mask;
    wire [WIDTH-1:0]       osc_mask;
    wire [WIDTH-1:0]       out_next;
    wire [WIDTH-1:0]       oe_next;

    assign analog_mask = bpa_analog(cfg_reg);
    assign osc_mask    = osc_on_pins ? `BPA_OSC_MASK : `BPA_ZERO8;

    // Write decode: port and latch offsets both land in the latch
    always @* begin
        dir_next   = dir_reg;
        latch_next = latch_reg;
        cfg_next   = cfg_reg;
        if (reg_wr) begin
            if (reg_addr == `BPA_OFS_PORT) begin
                latch_next = reg_wdata;
            end else if (reg_addr == `BPA_OFS_LATCH) begin
                latch_next = reg_wdata;
            end else if (reg_addr == `BPA_OFS_DIR) begin
                dir_next = reg_wdata;
            end else if (reg_addr == `BPA_OFS_ADCFG) begin
                cfg_next = reg_wdata[`BPA_CFG_W-1:0];
            end
        end
    end

    // Read decode; unmapped offsets read zero
    always @* begin
        rdata_next = {WIDTH{1'b0}};
        if (reg_rd) begin
            if (reg_addr == `BPA_OFS_PORT) begin
                rdata_next = pin_in & ~analog_mask & ~osc_mask;
            end else if (reg_addr == `BPA_OFS_LATCH) begin
                rdata_next = latch_reg & ~osc_mask;
            end else if (reg_addr == `BPA_OFS_DIR) begin
                rdata_next = dir_reg & ~osc_mask;
            end else if (reg_addr == `BPA_OFS_ADCFG) begin
                rdata_next = {{(WIDTH-`BPA_CFG_W){1'b0}}, cfg_reg};
            end
        end
    end

    // Register state; reset leaves pins inputs and analog pins analog
    always @(posedge core_clk) begin
        if (reset) begin
            dir_reg   <= `BPA_RST_DIR;
            latch_reg <= `BPA_RST_LATCH;
            cfg_reg   <= `BPA_RST_CFG;
            reg_rdata <= {WIDTH{1'b0}};
        end else begin
            dir_reg   <= dir_next;
            latch_reg <= latch_next;
            cfg_reg   <= cfg_next;
            reg_rdata <= rdata_next;
        end
    end

    // ************************************************
    // Pin drivers
    // ************************************************

    // Per pin driver choice from the next register values
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            wire gp_oe;
            wire gp_out;
            if (i == `BPA_PIN_OD) begin : g_od
                // Open drain: drive low for zero, release for one
                assign gp_oe  = ~dir_next[i] & ~latch_next[i];
                assign gp_out = 1'b0;
            end else begin : g_pp
                assign gp_oe  = ~dir_next[i];
                assign gp_out = latch_next[i];
            end
            // Peripheral owns its pin; oscillator pins never driven here
            assign oe_next[i]  = osc_mask[i] ? 1'b0 :
                                 periph_take[i] ? periph_oe[i] : gp_oe;
            assign out_next[i] = periph_take[i] ? periph_out[i] : gp_out;
        end
    endgenerate

    // Pin outputs follow writes at the completing edge
    always @(posedge core_clk) begin
        if (reset) begin
            pin_oe  <= {WIDTH{1'b0}};
            pin_out <= {WIDTH{1'b0}};
            timer_zero_clock_input <= 1'b0;
        end else begin
            pin_oe  <= oe_next;
            pin_out <= out_next;
            timer_zero_clock_input <= pin_in[`BPA_PIN_OD];
        end
    end

endmodule // bpa_port

// ===== verification/bpa_checker.sv
// Checker for the port block
`timescale 1ns/10ps
module bpa_checker #(parameter WIDTH = 8) (
    input wire core_clk, reset, reg_wr, reg_rd, osc_on_pins, timer_zero_clock_input,
    input wire [3:0] reg_addr,
    input wire [WIDTH-1:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, periph_take, periph_out, periph_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_lwr; reg_wr && (reg_addr == 4'h0 || reg_addr == 4'h2); endsequence
    sequence s_lrd; reg_rd && reg_addr == 4'h2; endsequence
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0) else $error("rdata not idle");
    a_latch_back: assert property (s_lwr ##1 !reg_wr ##1 s_lrd |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 3))
        else $error("latch readback");
    a_dir_oe: assert property (reg_wr && reg_addr == 4'h1 && periph_take[3:0] == 0
        |=> pin_oe[3:0] == ~$past(reg_wdata[3:0])) else $error("dir to oe");
    a_latch_out: assert property (reg_wr && (reg_addr == 4'h0 || reg_addr == 4'h2) && periph_take[3:0] == 0
        |=> ((pin_out[3:0] ^ $past(reg_wdata[3:0])) & pin_oe[3:0]) == 0) else $error("latch to pins");
    a_od_low: assert property (!$past(periph_take[4]) && pin_oe[4] |-> !pin_out[4]) else $error("pin4 od");
    a_timer_copy: assert property (!$past(reset) |-> timer_zero_clock_input == $past(pin_in[4]))
        else $error("timer input");
    a_osc_hiz: assert property ($past(osc_on_pins) && $past(periph_take[7:6]) == 0 |-> pin_oe[7:6] == 0)
        else $error("osc pins driven");
    a_osc_zero: assert property (reg_rd && reg_addr < 4'h3 && osc_on_pins |=> reg_rdata[7:6] == 0)
        else $error("osc bits read");
    a_periph_own: assert property (periph_take[5] |=> pin_oe[5] == $past(periph_oe[5])
        && pin_out[5] == $past(periph_out[5])) else $error("periph pin");
endmodule // bpa_checker
bind bpa_port bpa_checker #(.WIDTH(WIDTH)) i_chk (.*);

// ===== verification/bpa_pins.sv
// Model of the board outside the port pins
`timescale 1ns/10ps
module bpa_pins (
    input wire core_clk,
    input wire [7:0] pin_out, pin_oe, ext_val, ext_drv,
    output logic [7:0] pin_in
);
    logic tog = 1'b0;
    // Lines nobody drives wander; pin four floats up on its pull-up
    always @(negedge core_clk) tog <= ~tog;
    always_comb for (int i = 0; i < 8; i++)
        pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : (i == 4) ? 1'b1 : tog;
endmodule // bpa_pins

// ===== verification/bpa_port_tb.sv
// Self-checking bench for the port block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module bpa_port_tb;
    logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, osc = 0, tmr;
    logic [7:0] e;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, pin_in, pin_out, pin_oe, take = 0, p_out = 0, p_oe = 0, ev = 0, ed = 0, d, l;
    int n_mismatch = 0, samples_checked = 0;
    bpa_port i_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .osc_on_pins(osc), .periph_take(take), .periph_out(p_out), .periph_oe(p_oe),
        .timer_zero_clock_input(tmr));
    bpa_pins i_pins (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ev), .ext_drv(ed),
        .pin_in(pin_in));
    initial forever #20 core_clk = ~core_clk;
    task wr(input [3:0] a, input [7:0] v);
        @(posedge core_clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= v; end
        @(posedge core_clk) reg_wr <= 0;
    endtask
    task rd(input [3:0] a, input [7:0] e);
        @(posedge core_clk) begin reg_rd <= 1; reg_addr <= a; end
        @(posedge core_clk) reg_rd <= 0;
        #1 `CHK("rdata", e, reg_rdata)
    endtask
    // Pin levels a port read shows
    function [7:0] pexp(input [7:0] d, l, e, am, input o);
        pexp = ((d & e) | (~d & l)) & ~am & (o ? 8'h3F : 8'hFF);
    endfunction
    function [7:0] amask(input int c);
        amask = c < 11 ? 8'h2F : c == 11 ? 8'h0F : c == 12 ? 8'h07 : c == 13 ? 8'h03 : c == 14 ? 8'h01 : 8'h00;
    endfunction
    task end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin #200000; n_mismatch++; end_sim; end
    initial begin
        void'($urandom(32'h6f5456d4));
        repeat (2) @(posedge core_clk);
        reset <= 0;
        ed <= 8'hFF;
        ev <= 8'hFF;
        rd(1, 8'hFF);
        rd(2, 8'h00);
        rd(0, 8'hD0);
        for (int a = 4; a < 16; a++) rd(a, 0);
        for (int c = 0; c < 16; c++) begin
            wr(3, c);
            rd(0, pexp(8'hFF, 0, 8'hFF, amask(c), 0));
        end
        // All digital now, so any direction is safe for software
        repeat (40) begin
            @(posedge core_clk);
            d = $urandom;
            l = $urandom;
            ev <= $urandom;
            osc <= $urandom;
            ed <= d;
            wr(1, d);
            wr($urandom_range(1) ? 4'h0 : 4'h2, l);
            rd(2, l & (osc ? 8'h3F : 8'hFF));
            rd(1, d & (osc ? 8'h3F : 8'hFF));
            e = pexp(d, l, ev, 0, osc);
            rd(0, e);
            `CHK("timer_in", e[4], tmr)
            `CHK("pin_oe", ~d & ~(l & 8'h10) & (osc ? 8'h3F : 8'hFF), pin_oe)
            `CHK("pin_out", l & 8'hEF & pin_oe, pin_out & pin_oe)
        end
        repeat (20) @(posedge core_clk) begin take <= $urandom; p_out <= $urandom; p_oe <= $urandom; end
        end_sim;
    end
endmodule // bpa_port_tb
